// ### src/sisp_pkg.sv
package sisp_pkg;

  // system clock rate
  localparam int CLK_MHZ = 100;

  // device busy times, microseconds
  localparam int PAGE_WRITE_WAIT_TIME_US    = 4500;
  localparam int NV_BYTE_WRITE_WAIT_TIME_US = 3600;
  localparam int FULL_ERASE_WAIT_TIME_US    = 9000;

  // busy times as exact whole counts of system clock cycles
  localparam int PAGE_WAIT_CYC  = PAGE_WRITE_WAIT_TIME_US * CLK_MHZ;
  localparam int NV_WAIT_CYC    = NV_BYTE_WRITE_WAIT_TIME_US * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = FULL_ERASE_WAIT_TIME_US * CLK_MHZ;
  localparam int WAIT_CNT_W     = 20;

  // instruction framing
  localparam int          INSTR_BITS = 32;
  localparam logic [4:0]  CNT_HEAD_LAST = 5'h17;
  localparam logic [4:0]  CNT_WORD_LAST = 5'h1f;
  localparam logic [4:0]  CNT_BYTE4     = 5'h18;

  // opcodes and second-byte keys
  localparam logic [7:0] OP_ENABLE  = 8'hac;
  localparam logic [7:0] KEY_ENABLE = 8'h53;
  localparam logic [7:0] KEY_ERASE  = 8'h80;
  localparam logic [7:0] OP_POLL    = 8'hf0;
  localparam logic [7:0] OP_LD_HI   = 8'h48;
  localparam logic [7:0] OP_LD_LO   = 8'h40;
  localparam logic [7:0] OP_LD_EE   = 8'hc1;
  localparam logic [7:0] OP_RD_HI   = 8'h28;
  localparam logic [7:0] OP_RD_LO   = 8'h20;
  localparam logic [7:0] OP_RD_EE   = 8'ha0;
  localparam logic [7:0] OP_WR_PG   = 8'h4c;
  localparam logic [7:0] OP_WR_EE   = 8'hc0;
  localparam logic [7:0] OP_WR_EEPG = 8'hc2;

  // address layout
  localparam int FL_IDX_W = 6;
  localparam int FL_PG_W  = 8;
  localparam int FL_AW    = FL_IDX_W + FL_PG_W;
  localparam int EE_IDX_W = 2;
  localparam int EE_PG_W  = 4;
  localparam int EE_AW    = EE_IDX_W + EE_PG_W;
  localparam int EE_PG_BYTES = 4;

  localparam logic [7:0] ERASED_BYTE = 8'hff;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } sisp_instr_t;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
  } sisp_head_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FCOPY  = 3'b001,
    ST_EECOPY = 3'b010,
    ST_ERASE  = 3'b011,
    ST_WAIT   = 3'b100
  } sisp_state_t;

endpackage

// ### src/sisp_ram.sv
`timescale 1ns/10ps
module sisp_ram #(
  parameter int DW = 8,
  parameter int AW = 6
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

endmodule

// ### src/sisp_top.sv
// Operation
// - program, erase, load ignored until programming enable accepted in reset
// - mosi sampled on each rising sck edge
// - miso changes on each falling sck edge
// - second enable byte echoes on miso during third byte
// - page load index is six low word-address bits
// - page write targets page from eight upper address bits
// - eeprom writes overwrite directly, no prior erase needed
// - eeprom buffer by two low bits, page by four upper bits
// - eeprom page write changes only bytes loaded since last write
// - chip erase sets all locations to 0xff; 9 ms wait
// - read instructions return addressed content on miso
// - reset released high leaves programming mode, runs normally
// - poll byte bit 0 is 1 while an operation is pending
// - program memory addresses are word addresses
`timescale 1ns/10ps
module sisp_top import sisp_pkg::*; #(
  parameter logic [WAIT_CNT_W-1:0] PAGE_WAIT  = WAIT_CNT_W'(PAGE_WAIT_CYC),
  parameter logic [WAIT_CNT_W-1:0] NV_WAIT    = WAIT_CNT_W'(NV_WAIT_CYC),
  parameter logic [WAIT_CNT_W-1:0] ERASE_WAIT = WAIT_CNT_W'(ERASE_WAIT_CYC)
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic isp_sck,
  input  wire logic isp_mosi,
  input  wire logic isp_reset_n,
  output logic      isp_miso,
  output logic      operation_pending_flag,
  output logic      prog_mode,
  output logic      run_enable
);

  // link side, clocked by isp_sck
  logic              link_rst_n;
  logic [4:0]        bit_cnt_r;
  logic [31:0]       rx_r;
  logic [31:0]       rx_nxt;
  sisp_head_t        head_r;
  sisp_instr_t       word_r;
  logic              tgl_head_r;
  logic              tgl_word_r;
  logic [7:0]        tx_r;
  logic [7:0]        tx_nxt;
  logic              head_is_read;
  logic [7:0]        rd_data_r;

  // link logic is held while the reset pin is high
  assign link_rst_n = arst_n & ~isp_reset_n;
  assign rx_nxt     = {rx_r[30:0], isp_mosi};

  always_ff @(posedge isp_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_r      <= 32'h0;
      bit_cnt_r <= 5'h0;
    end else begin
      rx_r      <= rx_nxt;
      bit_cnt_r <= bit_cnt_r + 5'h1;
    end
  end

  // frame hand-off; toggles survive a reset-pin resync
  always_ff @(posedge isp_sck or negedge arst_n) begin
    if (!arst_n) begin
      head_r     <= '0;
      word_r     <= '0;
      tgl_head_r <= 1'b0;
      tgl_word_r <= 1'b0;
    end else if (link_rst_n) begin
      if (bit_cnt_r == CNT_HEAD_LAST) begin
        head_r     <= rx_nxt[23:0];
        tgl_head_r <= ~tgl_head_r;
      end
      if (bit_cnt_r == CNT_WORD_LAST) begin
        word_r     <= rx_nxt;
        tgl_word_r <= ~tgl_word_r;
      end
    end
  end

  assign head_is_read = head_r.op == OP_RD_LO || head_r.op == OP_RD_HI ||
                        head_r.op == OP_RD_EE || head_r.op == OP_POLL;

  always_comb begin
    if (bit_cnt_r[2:0] == 3'h0) begin
      if (bit_cnt_r == CNT_BYTE4 && head_is_read) begin
        tx_nxt = rd_data_r;
      end else begin
        tx_nxt = rx_r[7:0];
      end
    end else begin
      tx_nxt = {tx_r[6:0], 1'b0};
    end
  end

  always_ff @(negedge isp_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_r <= 8'h0;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  assign isp_miso = tx_r[7];

  // system side
  logic              rst_meta_r;
  logic              rst_sync_r;
  logic [2:0]        hsync_r;
  logic [2:0]        wsync_r;
  logic              ev_head;
  logic              ev_word;
  sisp_state_t       state_r;
  logic [FL_AW-1:0]  idx_r;
  logic [WAIT_CNT_W-1:0] busy_cnt_r;
  logic [FL_PG_W-1:0] page_r;
  logic [EE_PG_W-1:0] ee_pg_r;
  logic              cp_we_r;
  logic [FL_IDX_W-1:0] cp_idx_r;
  logic [7:0]        ee_buf_r [EE_PG_BYTES];
  logic [EE_PG_BYTES-1:0] ee_vld_r;
  logic              accept;
  logic [15:0]       w_addr;
  logic [15:0]       h_addr;
  logic              ld_lo;
  logic              ld_hi;
  logic              ld_ee;
  logic              wr_ee;
  logic              start_op;
  logic              fl_we;
  logic [FL_AW-1:0]  fl_waddr;
  logic [7:0]        fl_wlo;
  logic [7:0]        fl_whi;
  logic [7:0]        fl_rlo;
  logic [7:0]        fl_rhi;
  logic [7:0]        buf_rlo;
  logic [7:0]        buf_rhi;
  logic              ee_we;
  logic              ee_cp_we;
  logic              ee_er_we;
  logic [EE_AW-1:0]  ee_waddr;
  logic [7:0]        ee_wdata;
  logic [7:0]        ee_rdata;

  // reset pin and frame toggles, two flops before use
  // pin sync clears low so run_enable cannot pulse after reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
      hsync_r    <= 3'h0;
      wsync_r    <= 3'h0;
    end else begin
      rst_meta_r <= isp_reset_n;
      rst_sync_r <= rst_meta_r;
      hsync_r    <= {hsync_r[1:0], tgl_head_r};
      wsync_r    <= {wsync_r[1:0], tgl_word_r};
    end
  end

  assign ev_head = hsync_r[2] ^ hsync_r[1];
  assign ev_word = wsync_r[2] ^ wsync_r[1];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_mode  <= 1'b0;
      run_enable <= 1'b0;
    end else begin
      run_enable <= rst_sync_r;
      if (rst_sync_r) begin
        prog_mode <= 1'b0;
      end else if (ev_word && word_r.op == OP_ENABLE &&
                   word_r.b2 == KEY_ENABLE) begin
        prog_mode <= 1'b1;
      end
    end
  end

  // word addresses for program memory
  assign w_addr = {word_r.b2, word_r.b3};
  assign h_addr = {head_r.b2, head_r.b3};
  assign accept = ev_word && prog_mode && !rst_sync_r &&
                  state_r == ST_IDLE;
  assign ld_lo  = accept && word_r.op == OP_LD_LO;
  assign ld_hi  = accept && word_r.op == OP_LD_HI;
  assign ld_ee  = accept && word_r.op == OP_LD_EE;
  assign wr_ee  = accept && word_r.op == OP_WR_EE;
  assign start_op = accept && (word_r.op == OP_WR_PG || wr_ee ||
                    word_r.op == OP_WR_EEPG ||
                    (word_r.op == OP_ENABLE && word_r.b2 == KEY_ERASE));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ST_IDLE;
      idx_r      <= '0;
      busy_cnt_r <= '0;
      page_r     <= '0;
      ee_pg_r    <= '0;
    end else begin
      if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
      unique case (state_r)
        ST_IDLE: begin
          idx_r <= '0;
          if (accept && word_r.op == OP_WR_PG) begin
            page_r     <= w_addr[FL_AW-1:FL_IDX_W];
            busy_cnt_r <= PAGE_WAIT;
            state_r    <= ST_FCOPY;
          end else if (wr_ee) begin
            busy_cnt_r <= NV_WAIT;
            state_r    <= ST_WAIT;
          end else if (accept && word_r.op == OP_WR_EEPG) begin
            ee_pg_r    <= w_addr[EE_AW-1:EE_IDX_W];
            busy_cnt_r <= NV_WAIT;
            state_r    <= ST_EECOPY;
          end else if (start_op) begin
            busy_cnt_r <= ERASE_WAIT;
            state_r    <= ST_ERASE;
          end
        end
        ST_FCOPY: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r[FL_IDX_W-1:0] == {FL_IDX_W{1'b1}}) begin
            state_r <= ST_WAIT;
          end
        end
        ST_EECOPY: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r[EE_IDX_W-1:0] == {EE_IDX_W{1'b1}}) begin
            state_r <= ST_WAIT;
          end
        end
        ST_ERASE: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r == {FL_AW{1'b1}}) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (busy_cnt_r == '0) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      operation_pending_flag <= 1'b0;
    end else if (start_op) begin
      operation_pending_flag <= 1'b1;
    end else if (state_r == ST_WAIT && busy_cnt_r == '0) begin
      operation_pending_flag <= 1'b0;
    end
  end

  // page buffer to flash, one cycle behind the buffer read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cp_we_r  <= 1'b0;
      cp_idx_r <= '0;
    end else begin
      cp_we_r  <= state_r == ST_FCOPY;
      cp_idx_r <= idx_r[FL_IDX_W-1:0];
    end
  end

  // eeprom page buffer with loaded-byte marks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ee_vld_r <= '0;
      for (int i = 0; i < EE_PG_BYTES; i++) begin
        ee_buf_r[i] <= 8'h0;
      end
    end else if (ld_ee) begin
      ee_buf_r[word_r.b3[EE_IDX_W-1:0]] <= word_r.b4;
      ee_vld_r[word_r.b3[EE_IDX_W-1:0]] <= 1'b1;
    end else if (state_r == ST_EECOPY &&
                 idx_r[EE_IDX_W-1:0] == {EE_IDX_W{1'b1}}) begin
      ee_vld_r <= '0;
    end
  end

  assign fl_we    = cp_we_r || state_r == ST_ERASE;
  assign fl_waddr = state_r == ST_ERASE ? idx_r : {page_r, cp_idx_r};
  assign fl_wlo   = state_r == ST_ERASE ? ERASED_BYTE : buf_rlo;
  assign fl_whi   = state_r == ST_ERASE ? ERASED_BYTE : buf_rhi;

  assign ee_cp_we = state_r == ST_EECOPY &&
                    ee_vld_r[idx_r[EE_IDX_W-1:0]];
  assign ee_er_we = state_r == ST_ERASE &&
                    idx_r[FL_AW-1:EE_AW] == '0;
  assign ee_we    = wr_ee || ee_cp_we || ee_er_we;

  always_comb begin
    if (ee_er_we) begin
      ee_waddr = idx_r[EE_AW-1:0];
      ee_wdata = ERASED_BYTE;
    end else if (ee_cp_we) begin
      ee_waddr = {ee_pg_r, idx_r[EE_IDX_W-1:0]};
      ee_wdata = ee_buf_r[idx_r[EE_IDX_W-1:0]];
    end else begin
      ee_waddr = w_addr[EE_AW-1:0];
      ee_wdata = word_r.b4;
    end
  end

  sisp_ram #(.DW(8), .AW(FL_IDX_W)) u_buf_lo (
    .clk     (sys_clk),
    .we      (ld_lo),
    .waddr   (word_r.b3[FL_IDX_W-1:0]),
    .wdata   (word_r.b4),
    .raddr   (idx_r[FL_IDX_W-1:0]),
    .rdata_r (buf_rlo)
  );

  sisp_ram #(.DW(8), .AW(FL_IDX_W)) u_buf_hi (
    .clk     (sys_clk),
    .we      (ld_hi),
    .waddr   (word_r.b3[FL_IDX_W-1:0]),
    .wdata   (word_r.b4),
    .raddr   (idx_r[FL_IDX_W-1:0]),
    .rdata_r (buf_rhi)
  );

  sisp_ram #(.DW(8), .AW(FL_AW)) u_fl_lo (
    .clk     (sys_clk),
    .we      (fl_we),
    .waddr   (fl_waddr),
    .wdata   (fl_wlo),
    .raddr   (h_addr[FL_AW-1:0]),
    .rdata_r (fl_rlo)
  );

  sisp_ram #(.DW(8), .AW(FL_AW)) u_fl_hi (
    .clk     (sys_clk),
    .we      (fl_we),
    .waddr   (fl_waddr),
    .wdata   (fl_whi),
    .raddr   (h_addr[FL_AW-1:0]),
    .rdata_r (fl_rhi)
  );

  sisp_ram #(.DW(8), .AW(EE_AW)) u_ee (
    .clk     (sys_clk),
    .we      (ee_we),
    .waddr   (ee_waddr),
    .wdata   (ee_wdata),
    .raddr   (h_addr[EE_AW-1:0]),
    .rdata_r (ee_rdata)
  );

  // answer byte; held steady until the next header arrives
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 8'h0;
    end else if (ev_head) begin
      unique case (head_r.op)
        OP_RD_LO: rd_data_r <= fl_rlo;
        OP_RD_HI: rd_data_r <= fl_rhi;
        OP_RD_EE: rd_data_r <= ee_rdata;
        OP_POLL:  rd_data_r <= {7'h0, operation_pending_flag};
        default:  rd_data_r <= ERASED_BYTE;
      endcase
    end
  end

  a_mosi_sample: assert property (
    @(posedge isp_sck) disable iff (!link_rst_n)
    1'b1 |=> rx_r[0] == $past(isp_mosi))
    else $error("mosi bit not captured on rising sck");

  a_echo_byte: assert property (
    @(posedge isp_sck) disable iff (!link_rst_n)
    bit_cnt_r == 5'h10 |-> tx_r == rx_r[7:0])
    else $error("second byte not echoed during third byte");

  a_miso_shift: assert property (
    @(negedge isp_sck) disable iff (!link_rst_n)
    bit_cnt_r[2:0] != 3'h0 |=> tx_r[7] == $past(tx_r[6]))
    else $error("miso did not shift on falling sck");

  a_locked_refuse: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ev_word && !prog_mode && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("operation started before programming enable");

  a_leave_prog: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    rst_sync_r |=> !prog_mode && run_enable)
    else $error("programming mode kept after reset release");

  a_pending_poll: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    state_r != ST_IDLE |-> operation_pending_flag)
    else $error("pending flag low during an operation");

  a_erase_fill: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_ERASE |-> fl_we && fl_wlo == ERASED_BYTE &&
                            fl_whi == ERASED_BYTE)
    else $error("erase wrote a value other than 0xff");

  a_ee_loaded_only: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_EECOPY && ee_we |-> ee_vld_r[idx_r[EE_IDX_W-1:0]])
    else $error("eeprom byte written that was not loaded");

  a_page_select: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    accept && word_r.op == OP_WR_PG |=>
      ##1 fl_waddr == {$past(w_addr[FL_AW-1:FL_IDX_W], 2), 6'h0})
    else $error("page write aimed at the wrong page");

  a_read_answer: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ev_head && head_r.op == OP_RD_EE |=> rd_data_r == $past(ee_rdata))
    else $error("eeprom read answer wrong");

endmodule

// ### testbench/sisp_prog_model.sv
`timescale 1ns/10ps
module sisp_prog_model #(
  parameter int HALF_NS = 45
) (
  output logic      isp_sck,
  output logic      isp_mosi,
  output logic      isp_reset_n,
  input  wire logic isp_miso
);
  initial begin
    isp_sck     = 1'b0;
    isp_reset_n = 1'b0;
    isp_mosi    = 1'b0;
  end

  // level held well over two system clocks
  task automatic set_rst(input logic v);
    isp_reset_n = v;
    #(8*HALF_NS);
  endtask

  // one whole frame, msb first; sck rests low between frames
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    for (int i = 31; i >= 0; i--) begin
      isp_mosi = w[i];
      #(HALF_NS);
      r[i] = isp_miso;
      isp_sck = 1'b1;
      // answer needs a long high phase after the 24th rise
      #((i == 8) ? 2*HALF_NS : HALF_NS);
      isp_sck = 1'b0;
    end
    isp_mosi = ~isp_mosi;
    #(3*HALF_NS);
  endtask
endmodule

// ### testbench/tb_serial_isp_memory_programmer.sv
`timescale 1ns/10ps
module tb_serial_isp_memory_programmer;
  import sisp_pkg::*;
  logic        sys_clk;
  logic        arst_n;
  wire         isp_sck;
  wire         isp_mosi;
  wire         isp_reset_n;
  logic        isp_miso;
  logic        operation_pending_flag;
  logic        prog_mode;
  logic        run_enable;
  logic [31:0] rsp;
  int          bad_count;
  int          n_compared;

  sisp_top #(
    .PAGE_WAIT  (20'h00064),
    .NV_WAIT    (20'h007d0),
    .ERASE_WAIT (20'h04e20)
  ) dut (
    .sys_clk                (sys_clk),
    .arst_n                 (arst_n),
    .isp_sck                (isp_sck),
    .isp_mosi               (isp_mosi),
    .isp_reset_n            (isp_reset_n),
    .isp_miso               (isp_miso),
    .operation_pending_flag (operation_pending_flag),
    .prog_mode              (prog_mode),
    .run_enable             (run_enable)
  );

  sisp_prog_model prog (
    .isp_sck     (isp_sck),
    .isp_mosi    (isp_mosi),
    .isp_reset_n (isp_reset_n),
    .isp_miso    (isp_miso)
  );

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input logic [31:0] w);
    prog.xfer(w, rsp);
  endtask

  // outputs are read after the edge has settled them
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 30000; n++) begin
      @(posedge sys_clk);
      #1;
      if (operation_pending_flag === 1'b0) break;
    end
    if (n == 30000) begin
      bad_count++;
      $display("Error pending expected 0 seen %b", operation_pending_flag);
      final_report();
    end
  endtask

  task automatic t_enable();
    run({OP_ENABLE, KEY_ENABLE, 16'h0000});
    chk("echo", 8'h53, rsp[15:8]);
    settle();
    chk("prog_mode", 8'h01, {7'h00, prog_mode});
    $display("test enable done");
  endtask

  task automatic t_erase();
    run({OP_ENABLE, KEY_ERASE, 16'h0000});
    settle();
    chk("pending", 8'h01, {7'h00, operation_pending_flag});
    run({OP_POLL, 24'h000000});
    chk("poll busy", 8'h01, rsp[7:0]);
    wait_idle();
    run({OP_POLL, 24'h000001});
    chk("poll idle", 8'h00, rsp[7:0]);
    run({OP_RD_LO, 8'h3f, 8'hff, 8'h00});
    chk("flash lo", ERASED_BYTE, rsp[7:0]);
    run({OP_RD_HI, 24'h000000});
    chk("flash hi", ERASED_BYTE, rsp[7:0]);
    run({OP_RD_EE, 8'h00, 8'h3f, 8'h00});
    chk("eeprom", ERASED_BYTE, rsp[7:0]);
    $display("test erase done");
  endtask

  task automatic t_flash();
    run({OP_LD_LO, 8'h00, 8'hc5, 8'h11});
    run({OP_LD_HI, 8'h00, 8'hc5, 8'h22});
    run({OP_LD_LO, 8'h00, 8'h3f, 8'h33});
    run({OP_LD_HI, 8'h00, 8'h3f, 8'h44});
    run({OP_WR_PG, 8'h29, 8'h40, 8'h00});
    settle();
    chk("page busy", 8'h01, {7'h00, operation_pending_flag});
    wait_idle();
    run({OP_RD_LO, 8'h29, 8'h45, 8'h00});
    chk("word 5 lo", 8'h11, rsp[7:0]);
    run({OP_RD_HI, 8'h29, 8'h45, 8'h00});
    chk("word 5 hi", 8'h22, rsp[7:0]);
    run({OP_RD_LO, 8'h29, 8'h7f, 8'h00});
    chk("word 3f lo", 8'h33, rsp[7:0]);
    run({OP_RD_HI, 8'h29, 8'h7f, 8'h00});
    chk("word 3f hi", 8'h44, rsp[7:0]);
    run({OP_RD_LO, 8'h2a, 8'h45, 8'h00});
    chk("other page", ERASED_BYTE, rsp[7:0]);
    $display("test flash done");
  endtask

  task automatic t_eeprom();
    run({OP_WR_EE, 8'h00, 8'h09, 8'h3c});
    settle();
    chk("ee busy", 8'h01, {7'h00, operation_pending_flag});
    run({OP_WR_EE, 8'h00, 8'h0b, 8'h11});
    wait_idle();
    run({OP_RD_EE, 8'h00, 8'h0b, 8'h00});
    chk("refused write", ERASED_BYTE, rsp[7:0]);
    run({OP_WR_EE, 8'h00, 8'h09, 8'hc3});
    wait_idle();
    run({OP_RD_EE, 8'h00, 8'h09, 8'h00});
    chk("overwrite", 8'hc3, rsp[7:0]);
    run({OP_LD_EE, 8'h00, 8'h0a, 8'h77});
    run({OP_WR_EEPG, 8'h00, 8'h08, 8'h00});
    wait_idle();
    run({OP_RD_EE, 8'h00, 8'h0a, 8'h00});
    chk("ee page byte", 8'h77, rsp[7:0]);
    run({OP_RD_EE, 8'h00, 8'h09, 8'h00});
    chk("ee kept byte", 8'hc3, rsp[7:0]);
    run({OP_RD_EE, 8'h00, 8'h08, 8'h00});
    chk("ee unloaded", ERASED_BYTE, rsp[7:0]);
    $display("test eeprom done");
  endtask

  task automatic t_release();
    prog.set_rst(1'b1);
    settle();
    chk("run_enable", 8'h01, {7'h00, run_enable});
    chk("prog_mode off", 8'h00, {7'h00, prog_mode});
    prog.set_rst(1'b0);
    settle();
    chk("run_enable off", 8'h00, {7'h00, run_enable});
    run({OP_WR_EE, 8'h00, 8'h20, 8'h00});
    settle();
    chk("locked write", 8'h00, {7'h00, operation_pending_flag});
    t_enable();
    run({OP_RD_EE, 8'h00, 8'h20, 8'h00});
    chk("locked data", ERASED_BYTE, rsp[7:0]);
    $display("test release done");
  endtask

  initial begin
    bad_count  = 0;
    n_compared = 0;
    arst_n     = 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    // power-up wait, shortened
    repeat (200) @(posedge sys_clk);
    #3;
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_release();
    final_report();
  end
endmodule
